/* File: tb/qpt_event_source.sv */
// far side: free-running timer clock and a paced event source
`timescale 1ns/10ps
`default_nettype none
module qpt_event_source (
	input wire logic sys_clk_i,
	input wire logic run_i,
	output logic timer_clk_o,
	output logic event_o
);
	logic [5:0] ph = 6'h00;
	logic ev = 1'b0;
	// an event edge every 16 timer clocks, far slower than the limit
	always @(negedge sys_clk_i) begin
		ph <= ph + 6'h01;
		if (run_i && ph == 6'h3f) ev <= ~ev;
	end
	assign event_o = ev;
	// crystal-like clock runs free, four system cycles a period
	assign timer_clk_o = ph[1];
endmodule
`default_nettype wire

/* File: tb/qpt_timers_assertions.sv */
// port checker for the quad prescaled timers
`timescale 1ns/10ps
`default_nettype none
module qpt_timers_assertions
	import qpt_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic timer_clk_i,
	input wire logic timer_a_aux_input_i,
	input wire logic timer_b_aux_input_i,
	input wire logic gpio_line_four_i,
	input wire logic gpio_line_three_i,
	input wire logic edge_bit_line_four_i,
	input wire logic edge_bit_line_three_i,
	input wire qpt_ctrl_type ctrl_i,
	input wire logic [3:0] data_wr_i,
	input wire logic [7:0] data_i,
	input wire logic [1:0] out_clear_i,
	input wire logic [3:0] timer_irq_enable_i,
	input wire logic [1:0] line_irq_enable_i,
	input wire logic [3:0] timer_out_o,
	input wire logic [3:0] timer_irq_o,
	input wire logic [1:0] line_irq_o,
	input wire qpt_counts_type counts_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);
	logic [7:0] dreg_c;
	// shadow of the c data register, so reloads can be judged
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			dreg_c <= 8'h00;
		end else if (ce_i && data_wr_i[2]) begin
			dreg_c <= data_i;
		end
	end
	// three quiet cycles cover the one-cycle lag of the count and irq flops
	sequence s_c_idle;
		(ctrl_i.mode_c == 3'h0 && !data_wr_i[2]) [*3];
	endsequence
	// four cycles let the two-flop synchroniser settle
	sequence s_b_idle;
		(ctrl_i.mode_b > 4'h8 && timer_b_aux_input_i ^ edge_bit_line_three_i && !data_wr_i[1]) [*4];
	endsequence
	////////////////////////////////////////////////////////////////
	a_toggle_timeout:
		assert property (timer_irq_o[2] |-> timer_out_o[2] != $past(timer_out_o[2]))
		else $error("no toggle on timeout");
	a_reload_data:
		assert property (timer_irq_o[2] |-> counts_o.count_c == $past(dreg_c))
		else $error("wrong reload value");
	a_count_step:
		assert property ($changed(counts_o.count_c) && !$past(data_wr_i[2])
			&& $past(counts_o.count_c) != 8'h01 |-> counts_o.count_c == $past(counts_o.count_c) - 8'h01)
		else $error("count did not step by one");
	a_stop_freezes:
		assert property (s_c_idle |=> $stable(counts_o.count_c) && !timer_irq_o[2])
		else $error("stopped timer moved");
	a_pulse_gate:
		assert property (s_b_idle |=> $stable(counts_o.count_b))
		else $error("counted while gate inactive");
	a_event_edge:
		assert property (ctrl_i.mode_a == QPT_MODE_EVENT && edge_bit_line_four_i
			&& $rose(timer_a_aux_input_i) |-> ##[1:5] ($changed(counts_o.count_a) || $changed(timer_out_o[0])))
		else $error("event edge not counted");
	a_pulse_end_irq:
		assert property (ctrl_i.mode_b > 4'h8 && edge_bit_line_three_i && line_irq_enable_i[1]
			&& $fell(timer_b_aux_input_i) |-> ##[1:5] line_irq_o[1])
		else $error("no irq at pulse end");
	a_line_normal:
		assert property (ctrl_i.mode_a == 4'h0 && edge_bit_line_four_i && line_irq_enable_i[0]
			&& $rose(gpio_line_four_i) |-> ##[1:3] line_irq_o[0])
		else $error("no gpio line irq");
endmodule
`default_nettype wire

/* File: tb/testbench.sv */
// self-checking bench for the quad prescaled timers
`timescale 1ns/10ps
`default_nettype none
module testbench
	import qpt_pkg::*;
;
	localparam int TCK = 4; // system cycles per timer clock
	logic sys_clk_i, rst_i, ce_i, gpio_line_four_i, gpio_line_three_i, run;
	logic timer_b_aux_input_i, edge_bit_line_four_i, edge_bit_line_three_i;
	logic [3:0] data_wr_i, timer_irq_enable_i, timer_out_o, timer_irq_o;
	logic [1:0] out_clear_i, line_irq_enable_i, line_irq_o;
	logic [7:0] data_i;
	qpt_ctrl_type ctrl_i;
	qpt_counts_type counts_o;
	wire logic timer_clk_i, timer_a_aux_input_i;
	int error_cnt = 0;
	int samples_checked = 0;
	qpt_timers i_qpt_timers (.*);
	qpt_event_source i_qpt_event_source (.sys_clk_i(sys_clk_i), .run_i(run),
		.timer_clk_o(timer_clk_i), .event_o(timer_a_aux_input_i));
	////////////////////////////////////////////////////////////////
	task automatic check(input bit ok, input string msg);
		samples_checked++;
		if (!ok) begin
			error_cnt++;
			$display("ERROR at %0t: %s", $time, msg);
		end
	endtask
	// strobe held one cycle, then a gap so writes never merge
	task automatic wr(input int i, input logic [7:0] v);
		data_i = v;
		data_wr_i[i] = 1'b1;
		@(negedge sys_clk_i);
		data_wr_i = 4'h0;
		@(negedge sys_clk_i);
	endtask
	task automatic wait_irq(input int i, output int n);
		logic o;
		o = timer_out_o[i];
		n = 0;
		do begin
			@(negedge sys_clk_i);
			n++;
		end while (timer_irq_o[i] !== 1'b1 && n < 5000);
		check(n < 5000 && timer_out_o[i] === ~o, "timeout missing");
	endtask
	task automatic line_hits(input int i, output int h);
		h = 0;
		repeat (8) begin
			@(negedge sys_clk_i);
			if (line_irq_o[i] === 1'b1) h++;
		end
	endtask
	// first interval after a mode change may be short, so measure the second
	task automatic t_delay();
		int n;
		int ps[7] = '{4, 10, 16, 50, 64, 100, 200};
		for (int t = 0; t < QPT_NUM; t++) begin
			wr(t, 8'h01);
		end
		check(counts_o === {4{8'h01}}, "load");
		for (int p = 1; p < 8; p++) begin
			// all four fields move together, so every delay code reaches every timer
			ctrl_i = {4'(p), 4'(p), 3'(p), 3'(p)};
			for (int t = 0; t < QPT_NUM; t++) begin
				wait_irq(t, n);
				wait_irq(t, n);
				check(n == ps[p - 1] * TCK, "delay period");
			end
		end
		ctrl_i = '0;
	endtask
	task automatic t_reload();
		int n;
		logic [7:0] c;
		wr(2, 8'h00);
		ctrl_i.mode_c = 3'h1;
		wait_irq(2, n);
		wait_irq(2, n);
		check(n == 256 * 4 * TCK && counts_o.count_c === 8'h00, "256 pulses");
		repeat (40) @(negedge sys_clk_i);
		ctrl_i.mode_c = 3'h0;
		@(negedge sys_clk_i);
		c = counts_o.count_c;
		repeat (100) @(negedge sys_clk_i);
		check(counts_o.count_c === c, "stop");
		wr(2, 8'h05);
		check(counts_o.count_c === 8'h05, "stopped write");
		ctrl_i.mode_c = 3'h1;
		wr(2, 8'h09);
		check(counts_o.count_c <= 8'h05, "running write");
		wait_irq(2, n);
		check(counts_o.count_c === 8'h09, "deferred load");
		ctrl_i.mode_c = 3'h0;
	endtask
	// gate held for 64 cycles: exactly 16 ticks, four count pulses
	task automatic t_pulse();
		int h;
		edge_bit_line_three_i = 1'b1;
		line_irq_enable_i[1] = 1'b1;
		wr(1, 8'h32);
		ctrl_i.mode_b = 4'h9;
		repeat (100) @(negedge sys_clk_i);
		check(counts_o.count_b === 8'h32, "idle gate");
		timer_b_aux_input_i = 1'b1;
		line_hits(1, h);
		check(h == 0, "leading edge irq");
		wr(1, 8'h20);
		repeat (54) @(negedge sys_clk_i);
		timer_b_aux_input_i = 1'b0;
		line_hits(1, h);
		check(h == 1, "trailing edge irq");
		check(counts_o.count_b === 8'h32 - 8'(64 / (4 * TCK)), "width");
		ctrl_i.mode_b = 4'h0;
	endtask
	task automatic t_event();
		int k, li, ti;
		logic pv;
		edge_bit_line_four_i = 1'b1;
		line_irq_enable_i[0] = 1'b1;
		// edge bit first: moving it with the pin would leave the level unchanged
		@(negedge sys_clk_i);
		gpio_line_four_i = 1'b1;
		line_hits(0, li);
		check(li == 1, "gpio irq");
		wr(0, 8'h03);
		ctrl_i.mode_a = QPT_MODE_EVENT;
		{k, li, ti} = '0;
		pv = timer_a_aux_input_i;
		run <= 1'b1;
		for (int i = 0; i < 1000; i++) begin
			@(negedge sys_clk_i);
			if (i == 900) run <= 1'b0;
			if (timer_a_aux_input_i && !pv) k++;
			pv = timer_a_aux_input_i;
			if (line_irq_o[0] === 1'b1) li++;
			if (timer_irq_o[0] === 1'b1) ti++;
		end
		check(li == k && k > 3, "event irqs");
		check(ti == k / 3 && counts_o.count_a === 8'(3 - k % 3), "events");
	endtask
	task automatic final_report();
		$display("checks %0d errors %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		sys_clk_i = 1'b0;
		forever #10 sys_clk_i = ~sys_clk_i;
	end
	// cut a hang well past the longest expected run
	initial begin
		#(40000 * 20);
		error_cnt++;
		$display("ERROR at %0t: watchdog", $time);
		final_report();
	end
	initial begin
		{rst_i, ce_i, timer_irq_enable_i} = 6'h3f;
		{gpio_line_four_i, gpio_line_three_i, run, timer_b_aux_input_i, edge_bit_line_four_i,
			edge_bit_line_three_i, data_wr_i, data_i, out_clear_i, line_irq_enable_i, ctrl_i} = '0;
		repeat (4) @(negedge sys_clk_i);
		rst_i = 1'b0;
		t_delay();
		t_reload();
		t_pulse();
		t_event();
		final_report();
	end
endmodule
bind qpt_timers qpt_timers_assertions i_qpt_timers_assertions (.*);
`default_nettype wire

/* File: verilog/qpt_pkg.sv */
// package for the quad prescaled timers: mode codes, prescale table, carriers
package qpt_pkg;

	// counter and data width
	localparam int QPT_CNT_W = 8;

	// number of timers, and the two that have auxiliary inputs
	localparam int QPT_NUM = 4;
	localparam int QPT_NUM_AUX = 2;

	// timer indices
	localparam int QPT_TA = 0;
	localparam int QPT_TB = 1;
	localparam int QPT_TC = 2;
	localparam int QPT_TD = 3;

	// mode field positions for timers a and b
	localparam int QPT_MODE_HI = 3;
	localparam int QPT_PS_HI = 2;

	// mode codes
	localparam logic [3:0] QPT_MODE_STOP = 4'h0;
	localparam logic [3:0] QPT_MODE_EVENT = 4'h8;

	// prescale divisors, selected by the low three mode bits
	localparam logic [7:0] QPT_PS_1 = 8'h04;
	localparam logic [7:0] QPT_PS_2 = 8'h0a;
	localparam logic [7:0] QPT_PS_3 = 8'h10;
	localparam logic [7:0] QPT_PS_4 = 8'h32;
	localparam logic [7:0] QPT_PS_5 = 8'h40;
	localparam logic [7:0] QPT_PS_6 = 8'h64;
	localparam logic [7:0] QPT_PS_7 = 8'hc8;
	localparam logic [7:0] QPT_PS_NONE = 8'h01;

	// counter value that triggers reload and timeout
	localparam logic [7:0] QPT_CNT_ONE = 8'h01;

	// reset values
	localparam logic [7:0] QPT_CNT_RST = 8'h00;
	localparam logic [7:0] QPT_PRE_RST = 8'h00;

	// decoded operating mode
	typedef enum logic [1:0] {
		QPT_STOPPED = 2'b00,
		QPT_DELAY = 2'b01,
		QPT_EVENT = 2'b10,
		QPT_PULSE = 2'b11
	} qpt_mode_type;

	// mode fields for all four timers
	typedef struct packed {
		logic [3:0] mode_a;
		logic [3:0] mode_b;
		logic [2:0] mode_c;
		logic [2:0] mode_d;
	} qpt_ctrl_type;

	// main counter values of all four timers
	typedef struct packed {
		logic [7:0] count_a;
		logic [7:0] count_b;
		logic [7:0] count_c;
		logic [7:0] count_d;
	} qpt_counts_type;

endpackage

/* File: verilog/qpt_timers.sv */
// four prescaled 8-bit down-counter timers with delay, pulse-width and event modes
// How it works
// - four 8-bit prescaled down counters, shared timer clock
// - output toggles on each timeout, a and b forced low by a clear, holds otherwise
// - a and b full modes; c, d delay
// - delay: prescaler runs, each pulse decrements counter
// - at 01, next pulse reloads and times out
// - timeout reaches own channel, gated by enable
// - prescale change: first timeout irregular, then correct
// - reload 01 every pulse; 00 every 256
// - pulse width: count only while aux active
// - channels four, three follow aux in aux modes
// - edge bit sets aux active level
// - pulse width interrupt on opposite transition
// - data write while active waits for 01
// - leaving pulse mode restores normal edge sense
// - event mode: no prescaler, aux edges count
// - edge bit one rising, zero falling counts
// - edge bit change may yield spurious count
// - event edges also raise borrowed channel interrupt
// - a, b decode four-bit mode field
// - c, d decode three-bit mode field
// - stopped write loads counter; running write deferred
// - stop keeps counter, drops prescaler residue
`timescale 1ns/10ps
`default_nettype none

module qpt_timers
	import qpt_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic timer_clk_i,
	input wire logic timer_a_aux_input_i,
	input wire logic timer_b_aux_input_i,
	input wire logic gpio_line_four_i,
	input wire logic gpio_line_three_i,
	input wire logic edge_bit_line_four_i,
	input wire logic edge_bit_line_three_i,
	input wire qpt_ctrl_type ctrl_i,
	input wire logic [3:0] data_wr_i,
	input wire logic [7:0] data_i,
	input wire logic [1:0] out_clear_i,
	input wire logic [3:0] timer_irq_enable_i,
	input wire logic [1:0] line_irq_enable_i,
	output logic [3:0] timer_out_o,
	output logic [3:0] timer_irq_o,
	output logic [1:0] line_irq_o,
	output qpt_counts_type counts_o
);

	////////////////////////////////////////////////////////////////////////
	// decoding helpers

	// operating mode from a four-bit field; c and d arrive with bit 3 low
	function automatic qpt_mode_type mode_of(input logic [3:0] m);
		qpt_mode_type r;
		r = QPT_DELAY;
		if (m == QPT_MODE_STOP) begin
			r = QPT_STOPPED;
		end else if (m == QPT_MODE_EVENT) begin
			r = QPT_EVENT;
		end else if (m[QPT_MODE_HI]) begin
			r = QPT_PULSE;
		end
		return r;
	endfunction

	// a level that is high now and was low at the previous sample; the arm
	// input keeps reset values from being taken for real edges
	function automatic logic [1:0] rise_of(input logic [1:0] cur, input logic [1:0] prev,
		input logic armed);
		return cur & ~prev & {2{armed}};
	endfunction

	// prescale divisor from the low three bits of the field
	function automatic logic [7:0] prescale_of(input logic [3:0] m);
		logic [7:0] r;
		r = QPT_PS_NONE;
		case (m[QPT_PS_HI:0])
			3'h1: r = QPT_PS_1;
			3'h2: r = QPT_PS_2;
			3'h3: r = QPT_PS_3;
			3'h4: r = QPT_PS_4;
			3'h5: r = QPT_PS_5;
			3'h6: r = QPT_PS_6;
			3'h7: r = QPT_PS_7;
			default: r = QPT_PS_NONE;
		endcase
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// state

	logic tclk_q;
	logic [1:0] aux_meta;
	logic [1:0] aux_sync;
	logic [1:0] ev_level_q;
	logic [1:0] line_level_q;
	logic [3:0] mode_q [QPT_NUM];
	logic [7:0] pre [QPT_NUM];
	logic [7:0] cnt [QPT_NUM];
	logic [7:0] data_reg [QPT_NUM];
	logic [3:0] out_q;
	// shift of ones after reset; its top bit arms the edge detectors
	logic [2:0] settle;

	// combinational per-timer terms
	logic tick;
	logic [3:0] mode_field [QPT_NUM];
	qpt_mode_type mode_now [QPT_NUM];
	logic [7:0] ps_now [QPT_NUM];
	logic [3:0] advance;
	logic [3:0] pre_wrap;
	logic [3:0] count_pulse;
	logic [3:0] timeout;
	logic [1:0] edge_bit;
	logic [1:0] aux_active;
	logic [1:0] ev_level;
	logic [1:0] ev_rise;
	logic [1:0] line_src;
	logic [1:0] line_level;

	// widen c and d mode fields; their top bit stays low so they only see stop or delay
	assign mode_field[QPT_TA] = ctrl_i.mode_a;
	assign mode_field[QPT_TB] = ctrl_i.mode_b;
	assign mode_field[QPT_TC] = {1'b0, ctrl_i.mode_c};
	assign mode_field[QPT_TD] = {1'b0, ctrl_i.mode_d};

	// bit 0 serves timer a, bit 1 timer b, in the order of the aux inputs
	assign edge_bit = {edge_bit_line_three_i, edge_bit_line_four_i};

	// timer clock taken as a sampled level; its rising edge is one timer tick
	assign tick = timer_clk_i & ~tclk_q;

	////////////////////////////////////////////////////////////////////////
	// auxiliary input conditioning

	// level at which the aux input enables counting, and the event level
	// compared against the edge bit, so an edge bit write can look like an edge
	always_comb begin
		for (int j = 0; j < QPT_NUM_AUX; j++) begin
			aux_active[j] = ~(aux_sync[j] ^ edge_bit[j]);
			ev_level[j] = aux_active[j];
		end
	end

	// an event is a rise of that level, once the synchronisers are armed
	assign ev_rise = rise_of(ev_level, ev_level_q, settle[2]);

	// interrupt source of the borrowed channels: aux in aux modes, else gpio
	always_comb begin
		for (int j = 0; j < QPT_NUM_AUX; j++) begin
			line_src[j] = (mode_now[j] == QPT_PULSE || mode_now[j] == QPT_EVENT) ?
				aux_sync[j] : (j == 0 ? gpio_line_four_i : gpio_line_three_i);
			// pulse width mode flips the sense so the pulse end interrupts
			line_level[j] = ~(line_src[j] ^ edge_bit[j]) ^
				(mode_now[j] == QPT_PULSE);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// per-timer count pulse decoding

	always_comb begin
		for (int i = 0; i < QPT_NUM; i++) begin
			mode_now[i] = mode_of(mode_field[i]);
			ps_now[i] = prescale_of(mode_field[i]);
			advance[i] = 1'b0;
			count_pulse[i] = 1'b0;
			case (mode_now[i])
				QPT_DELAY: begin
					advance[i] = tick;
				end
				QPT_PULSE: begin
					// only a and b reach here; c, d never carry bit 3
					advance[i] = tick & aux_active[i[0]];
				end
				QPT_EVENT: begin
					count_pulse[i] = ev_rise[i[0]];
				end
				default: begin
					advance[i] = 1'b0;
				end
			endcase
			pre_wrap[i] = advance[i] & (pre[i] == ps_now[i] - 8'h01);
			if (mode_now[i] == QPT_DELAY || mode_now[i] == QPT_PULSE) begin
				count_pulse[i] = pre_wrap[i];
			end
			timeout[i] = count_pulse[i] & (cnt[i] == QPT_CNT_ONE);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// input sampling and synchronisers

	// two flops per aux input; the first is read by the second only
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			aux_meta <= 2'h0;
			aux_sync <= 2'h0;
		end else if (ce_i) begin
			aux_meta <= {timer_b_aux_input_i, timer_a_aux_input_i};
			aux_sync <= aux_meta;
		end
	end

	// edge detectors stay disarmed until the synchroniser and previous-level
	// flops hold real samples; their zero reset would otherwise read as an
	// edge on any line that idles at the opposite level
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			settle <= 3'h0;
		end else if (ce_i) begin
			settle <= {settle[1:0], 1'b1};
		end
	end

	// previous levels for tick and edge detection
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			tclk_q <= 1'b0;
			ev_level_q <= 2'h0;
			line_level_q <= 2'h0;
		end else if (ce_i) begin
			tclk_q <= timer_clk_i;
			ev_level_q <= ev_level;
			line_level_q <= line_level;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// prescalers

	// a stop, an event mode or a new mode field clears the residue; the first
	// interval after a change is therefore irregular, and can be longer than the new one
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			for (int i = 0; i < QPT_NUM; i++) begin
				pre[i] <= QPT_PRE_RST;
				mode_q[i] <= QPT_MODE_STOP;
			end
		end else if (ce_i) begin
			for (int i = 0; i < QPT_NUM; i++) begin
				mode_q[i] <= mode_field[i];
				if (mode_now[i] == QPT_STOPPED || mode_now[i] == QPT_EVENT) begin
					pre[i] <= QPT_PRE_RST;
				end else if (mode_field[i] != mode_q[i]) begin
					pre[i] <= QPT_PRE_RST;
				end else if (pre_wrap[i]) begin
					pre[i] <= QPT_PRE_RST;
				end else if (advance[i]) begin
					pre[i] <= pre[i] + 8'h01;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// data registers and main counters

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			for (int i = 0; i < QPT_NUM; i++) begin
				data_reg[i] <= QPT_CNT_RST;
				cnt[i] <= QPT_CNT_RST;
			end
		end else if (ce_i) begin
			for (int i = 0; i < QPT_NUM; i++) begin
				if (data_wr_i[i]) begin
					data_reg[i] <= data_i;
				end
				if (data_wr_i[i] && mode_now[i] == QPT_STOPPED) begin
					cnt[i] <= data_i;
				end else if (timeout[i]) begin
					// reload from the held register; a running write waits here
					cnt[i] <= data_reg[i];
				end else if (count_pulse[i]) begin
					// 00 wraps to ff, giving 256 pulses per timeout
					cnt[i] <= cnt[i] - 8'h01;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs

	// output lines toggle on timeout; a and b can be forced low by a clear
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			out_q <= 4'h0;
		end else if (ce_i) begin
			for (int i = 0; i < QPT_NUM; i++) begin
				if (i < QPT_NUM_AUX && out_clear_i[i[0]]) begin
					out_q[i] <= 1'b0;
				end else if (timeout[i]) begin
					out_q[i] <= ~out_q[i];
				end
			end
		end
	end

	// timeout pulses, gated by each channel's enable
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			timer_irq_o <= 4'h0;
		end else if (ce_i) begin
			timer_irq_o <= timeout & timer_irq_enable_i;
		end else begin
			// a frozen block holds no pulse high across stalled cycles
			timer_irq_o <= 4'h0;
		end
	end

	// borrowed channel pulses; event-mode aux edges land here as the same rise
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			line_irq_o <= 2'h0;
		end else if (ce_i) begin
			line_irq_o <= rise_of(line_level, line_level_q, settle[2]) &
				line_irq_enable_i;
		end else begin
			line_irq_o <= 2'h0;
		end
	end

	// counts and outputs wired straight from their flops
	assign timer_out_o = out_q;
	assign counts_o.count_a = cnt[QPT_TA];
	assign counts_o.count_b = cnt[QPT_TB];
	assign counts_o.count_c = cnt[QPT_TC];
	assign counts_o.count_d = cnt[QPT_TD];

endmodule

`default_nettype wire
